// File: inc/glcd_defines.svh
// constants of the lcd command decoder: codes, fields, timing
// assumes a 100 MHz clock on both ends
//
// Notes on behaviour
// - command/data line high for commands, low data
// - font select high six-wide cells, low eight
// - 40h loads text home, low byte first
// - 42h loads graphic home, low byte first
// - mode set low bits pick layer merge
// - mode set bit 3 picks external patterns
// - display mode: off, cursor, blink bits
// - display mode bits 2,3 enable text, graphic
// - c0 write then increment, c1 read increment
// - c2 write then decrement, c3 read decrement
// - c4 write, c5 read, pointer unchanged
// - auto mode streams data until auto reset
// - peek outside graphic area sets error flag
// - bit set/reset touches exactly one bit
`ifndef GLCD_DEFINES_SVH
`define GLCD_DEFINES_SVH
// ****************
// command codes
// ****************
`define GL_C_CURSOR   8'h21
`define GL_C_OFFSET   8'h22
`define GL_C_PTR      8'h24
`define GL_C_THOME    8'h40
`define GL_C_TAREA    8'h41
`define GL_C_GHOME    8'h42
`define GL_C_GAREA    8'h43
`define GL_C_AUTO_WR  8'hB0
`define GL_C_AUTO_RD  8'hB1
`define GL_C_AUTO_END 8'hB2
`define GL_C_PEEK     8'hE0
`define GL_N_MODE     4'h8
`define GL_N_DISP     4'h9
`define GL_N_CLINES   5'h14
`define GL_N_DATA     5'h18
`define GL_N_BIT      4'hF
// ****************
// status bits and geometry
// ****************
`define GL_ST_BASE    8'h23
`define GL_ST_AUTO_RD 2
`define GL_ST_AUTO_WR 3
`define GL_ST_PEEK    6
`define GL_MEM_AW     13
`define GL_MEM_BYTES  8192
`define GL_ROW_SH     6
`define GL_CELL_NARROW 4'h6
`define GL_CELL_WIDE   4'h8
// ****************
// host timing and register map
// ****************
`define GL_STB_NS     80
`define GL_CLK_NS     10
`define GL_STB_CYC    ((`GL_STB_NS + `GL_CLK_NS - 1) / `GL_CLK_NS)
`define GL_R_XFER     4'h0
`define GL_R_STAT     4'h4
`define GL_R_CTRL     4'h8
`define GL_R_IRQ      4'hC
`define GL_R_IMASK    4'hD
`define GL_IRQ_WR     0
`define GL_IRQ_RD     1
`endif

// File: inc/glcd_pkg.sv
// types shared by both ends of the lcd command link
// assumes glcd_defines.svh for the numeric constants
package glcd_pkg;
  typedef enum logic [1:0] {GLCD_AUTO_OFF, GLCD_AUTO_WR, GLCD_AUTO_RD} glcd_auto_e;
  typedef enum logic [1:0] {GLCD_H_IDLE, GLCD_H_SETUP, GLCD_H_STB, GLCD_H_HOLD} glcd_hst_e;
  typedef struct packed {
    logic [15:0] ptr;
    logic [15:0] thome;
    logic [7:0]  tcols;
    logic [15:0] ghome;
    logic [7:0]  gcols;
    logic [15:0] curs;
    logic [7:0]  offs;
    logic [2:0]  merge;
    logic        cgext;
    logic [3:0]  disp;
    logic [2:0]  clines;
    glcd_auto_e  auto;
    logic [15:0] ops;
    logic [7:0]  rdl;
    logic        perr;
    logic        wr_p;
    logic        rd_p;
  } glcd_dev_s;
endpackage : glcd_pkg

// File: inc/glcd_bus_if.sv
// parallel link between host and lcd decoder
// the shared data bus idles high when nobody drives it
`timescale 1ns/100ps
`default_nettype none
interface glcd_bus_if;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       cd;
  logic       rst_n;
  logic       fs;
  logic [7:0] h_db_o;
  logic       h_db_oe_n;
  logic [7:0] d_db_o;
  logic       d_db_oe_n;
  logic [7:0] db;
  assign db = !h_db_oe_n ? h_db_o : (!d_db_oe_n ? d_db_o : 8'hFF);
  modport dev  (input cs_n, wr_n, rd_n, cd, rst_n, fs, db, output d_db_o, d_db_oe_n);
  modport host (output cs_n, wr_n, rd_n, cd, rst_n, fs, h_db_o, h_db_oe_n, input db);
endinterface : glcd_bus_if
`default_nettype wire

// File: core/glcd_sync.sv
// two-flop synchroniser for pins entering the clock domain
// assumes the pins idle at the reset value given
`timescale 1ns/100ps
`default_nettype none
module glcd_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '1
) (
  // clock, reset, enable
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  // pins
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= INIT;
      sync   <= INIT;
    end else if (ce) begin
      meta_q <= pin;
      sync   <= meta_q;
    end
  end
endmodule : glcd_sync
`default_nettype wire

// File: core/glcd_dev.sv
// lcd command decoder: the device end of the parallel link
// assumes the host holds each strobe for several clocks
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "glcd_defines.svh"
module glcd_dev import glcd_pkg::*; (
  // clock, reset, enable
  input  wire logic   clock,
  input  wire logic   sys_rst,
  input  wire logic   ce,
  // link
  glcd_bus_if.dev     bus,
  // display state
  output logic [15:0] ptr,
  output logic [15:0] text_home,
  output logic [7:0]  text_cols,
  output logic [15:0] gfx_home,
  output logic [7:0]  gfx_cols,
  output logic [15:0] cursor_pos,
  output logic [7:0]  offset_reg,
  output logic [2:0]  merge_mode,
  output logic        cg_external,
  output logic        text_on,
  output logic        gfx_on,
  output logic        cursor_on,
  output logic        cursor_blink,
  output logic [2:0]  cursor_lines,
  output logic [3:0]  cell_width,
  output logic        auto_active,
  output logic        peek_error_flag
);
  // ****************
  // pin synchronisers
  // ****************
  logic       cs_s, wr_s, rd_s, cd_s, rst_n_s, fs_s;
  logic [7:0] db_s;
  // reset values match the idle pins: strobes high, cd, rst_n and fs low, bus pulled high
  glcd_sync #(.W(14), .INIT(14'h38FF)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin     ({bus.cs_n, bus.wr_n, bus.rd_n, bus.cd, bus.rst_n, bus.fs, bus.db}),
    .sync    ({cs_s, wr_s, rd_s, cd_s, rst_n_s, fs_s, db_s})
  );

  // ****************
  // display memory
  // ****************
  logic [7:0]            mem [0:`GL_MEM_BYTES-1];
  logic                  mwe;
  logic [`GL_MEM_AW-1:0] maddr;
  logic [7:0]            mwd;
  logic [7:0]            rd_byte;
  assign maddr   = ptr[`GL_MEM_AW-1:0];
  assign rd_byte = mem[maddr];
  always_ff @(posedge clock) begin
    if (ce && mwe) begin
      mem[maddr] <= mwd;
    end
  end

  // ****************
  // decoder state
  // ****************
  glcd_dev_s   q, d;
  logic        wr_ev, rd_end;
  logic [7:0]  cmd;
  logic [7:0]  bmask;
  logic [15:0] gend;
  logic        in_gfx;
  assign wr_ev  = q.wr_p && !wr_s && !cs_s;
  assign rd_end = !q.rd_p && rd_s && !cs_s;
  assign cmd    = db_s;
  assign bmask  = 8'h01 << cmd[2:0];
  assign gend   = q.ghome + {2'b00, q.gcols, 6'b000000};
  assign in_gfx = (q.ptr >= q.ghome) && (q.ptr < gend);

  always_comb begin
    d      = q;
    d.wr_p = wr_s;
    d.rd_p = rd_s;
    mwe    = 1'b0;
    mwd    = q.ops[15:8];
    if (wr_ev && !cd_s) begin
      if (q.auto == GLCD_AUTO_WR) begin
        mwe   = 1'b1;
        mwd   = db_s;
        d.ptr = q.ptr + 16'h0001;
      end else if (q.auto == GLCD_AUTO_OFF) begin
        d.ops = {db_s, q.ops[15:8]};
      end
    end else if (wr_ev && cd_s) begin
      if (q.auto != GLCD_AUTO_OFF) begin
        // commands other than auto reset are refused while streaming
        if (cmd == `GL_C_AUTO_END) begin
          d.auto = GLCD_AUTO_OFF;
        end
      end else begin
        d.perr = 1'b0;
        if (cmd == `GL_C_CURSOR) begin
          d.curs = q.ops;
        end else if (cmd == `GL_C_OFFSET) begin
          d.offs = q.ops[7:0];
        end else if (cmd == `GL_C_PTR) begin
          d.ptr = q.ops;
        end else if (cmd == `GL_C_THOME) begin
          d.thome = q.ops;
        end else if (cmd == `GL_C_TAREA) begin
          d.tcols = q.ops[7:0];
        end else if (cmd == `GL_C_GHOME) begin
          d.ghome = q.ops;
        end else if (cmd == `GL_C_GAREA) begin
          d.gcols = q.ops[7:0];
        end else if (cmd[7:4] == `GL_N_MODE) begin
          d.merge = cmd[2:0];
          d.cgext = cmd[3];
        end else if (cmd[7:4] == `GL_N_DISP) begin
          d.disp = cmd[3:0];
        end else if (cmd[7:3] == `GL_N_CLINES) begin
          d.clines = cmd[2:0];
        end else if (cmd == `GL_C_AUTO_WR) begin
          d.auto = GLCD_AUTO_WR;
        end else if (cmd == `GL_C_AUTO_RD) begin
          d.auto = GLCD_AUTO_RD;
        end else if (cmd[7:3] == `GL_N_DATA && cmd[2:1] != 2'b11) begin
          // bit 0 picks read, bits 2:1 pick the pointer step
          if (cmd[0]) begin
            d.rdl = rd_byte;
          end else begin
            mwe = 1'b1;
          end
          if (cmd[2:1] == 2'b00) begin
            d.ptr = q.ptr + 16'h0001;
          end else if (cmd[2:1] == 2'b01) begin
            d.ptr = q.ptr - 16'h0001;
          end
        end else if (cmd == `GL_C_PEEK) begin
          if (in_gfx) begin
            d.rdl = rd_byte;
          end else begin
            d.perr = 1'b1;
          end
        end else if (cmd[7:4] == `GL_N_BIT) begin
          mwe = 1'b1;
          mwd = cmd[3] ? (rd_byte | bmask) : (rd_byte & ~bmask);
        end
      end
    end
    if (q.auto == GLCD_AUTO_RD) begin
      // keep the read latch on the byte under the pointer
      // status reads must not step the pointer
      if (rd_end && !cd_s) begin
        d.ptr = q.ptr + 16'h0001;
      end else if (rd_s) begin
        d.rdl = rd_byte;
      end
    end
    if (!rst_n_s) begin
      d      = '0;
      d.wr_p = wr_s;
      d.rd_p = rd_s;
      mwe    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************
  // read-back drive
  // ****************
  logic [7:0] db_q;
  logic       oe_n_q;
  logic [7:0] status;
  always_comb begin
    status = `GL_ST_BASE;
    status[`GL_ST_AUTO_RD] = (q.auto == GLCD_AUTO_RD);
    status[`GL_ST_AUTO_WR] = (q.auto == GLCD_AUTO_WR);
    status[`GL_ST_PEEK]    = q.perr;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      db_q   <= 8'hFF;
      oe_n_q <= 1'b1;
    end else if (ce) begin
      db_q   <= cd_s ? status : q.rdl;
      oe_n_q <= cs_s || rd_s;
    end
  end
  assign bus.d_db_o    = db_q;
  assign bus.d_db_oe_n = oe_n_q;

  // ****************
  // user view
  // ****************
  assign ptr             = q.ptr;
  assign text_home       = q.thome;
  assign text_cols       = q.tcols;
  assign gfx_home        = q.ghome;
  assign gfx_cols        = q.gcols;
  assign cursor_pos      = q.curs;
  assign offset_reg      = q.offs;
  assign merge_mode      = q.merge;
  assign cg_external     = q.cgext;
  assign gfx_on          = q.disp[3];
  assign text_on         = q.disp[2];
  assign cursor_on       = q.disp[1];
  assign cursor_blink    = q.disp[0];
  assign cursor_lines    = q.clines;
  assign cell_width      = fs_s ? `GL_CELL_NARROW : `GL_CELL_WIDE;
  assign auto_active     = (q.auto != GLCD_AUTO_OFF);
  assign peek_error_flag = q.perr;
endmodule : glcd_dev
`default_nettype wire

// File: core/glcd_host.sv
// host controller: turns register writes into link transfers
// assumes software waits for busy low between transfers
`timescale 1ns/100ps
`default_nettype none
`include "glcd_defines.svh"
module glcd_host import glcd_pkg::*; (
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  input  wire logic       re,
  output logic      [7:0] rdata,
  output logic            irq,
  // link
  glcd_bus_if.host        bus
);
  logic [7:0] db_s;
  glcd_sync #(.W(8), .INIT(8'hFF)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin     (bus.db),
    .sync    (db_s)
  );

  // ****************
  // transfer engine
  // ****************
  glcd_hst_e  st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] out_q, out_d, rb_q, rb_d;
  logic       rd_q, rd_d, cd_q, cd_d;
  logic [1:0] ctl_q, ctl_d, ist_q, ist_d, msk_q, msk_d;
  logic [7:0] rdata_d;
  logic       done;
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    out_d = out_q;
    rb_d  = rb_q;
    rd_d  = rd_q;
    cd_d  = cd_q;
    ctl_d = ctl_q;
    msk_d = msk_q;
    ist_d = ist_q;
    done  = 1'b0;
    unique case (st_q)
      GLCD_H_IDLE: begin
        // one transfer at a time, later writes are dropped
        if (we && addr == `GL_R_XFER) begin
          out_d = wdata;
          st_d  = GLCD_H_SETUP;
        end
      end
      GLCD_H_SETUP: begin
        cnt_d = 4'(`GL_STB_CYC);
        st_d  = GLCD_H_STB;
      end
      GLCD_H_STB: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          rb_d = db_s;
          st_d = GLCD_H_HOLD;
        end
      end
      GLCD_H_HOLD: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(`GL_STB_CYC)) begin
          done = 1'b1;
          st_d = GLCD_H_IDLE;
        end
      end
    endcase
    if (we && addr == `GL_R_XFER + 4'h1 && st_q == GLCD_H_IDLE) begin
      rd_d = wdata[1];
      cd_d = wdata[0];
    end
    if (we && addr == `GL_R_CTRL) begin
      ctl_d = wdata[1:0];
    end
    if (we && addr == `GL_R_IMASK) begin
      msk_d = wdata[1:0];
    end
    if (re && addr == `GL_R_IRQ) begin
      ist_d = 2'b00;
    end
    // a done event beats a clearing read
    if (done) begin
      ist_d[rd_q ? `GL_IRQ_RD : `GL_IRQ_WR] = 1'b1;
    end
    rdata_d = 8'h00;
    if (re) begin
      unique case (addr)
        `GL_R_STAT:  rdata_d = {7'h00, st_q != GLCD_H_IDLE};
        `GL_R_STAT + 4'h1: rdata_d = rb_q;
        `GL_R_CTRL:  rdata_d = {6'h00, ctl_q};
        `GL_R_IRQ:   rdata_d = {6'h00, ist_q};
        `GL_R_IMASK: rdata_d = {6'h00, msk_q};
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q  <= GLCD_H_IDLE;
      cnt_q <= 4'h0;
      out_q <= 8'h00;
      rb_q  <= 8'h00;
      rd_q  <= 1'b0;
      cd_q  <= 1'b0;
      ctl_q <= 2'b00;
      ist_q <= 2'b00;
      msk_q <= 2'b00;
      rdata <= 8'h00;
    end else if (ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      rb_q  <= rb_d;
      rd_q  <= rd_d;
      cd_q  <= cd_d;
      ctl_q <= ctl_d;
      ist_q <= ist_d;
      msk_q <= msk_d;
      rdata <= rdata_d;
    end
  end

  // ****************
  // pins
  // ****************
  logic act_q, stb_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      act_q <= 1'b0;
      stb_q <= 1'b0;
    end else if (ce) begin
      act_q <= (st_d != GLCD_H_IDLE);
      stb_q <= (st_d == GLCD_H_STB);
    end
  end
  assign bus.cs_n      = !act_q;
  assign bus.wr_n      = !(stb_q && !rd_q);
  assign bus.rd_n      = !(stb_q && rd_q);
  assign bus.cd        = cd_q;
  assign bus.rst_n     = ctl_q[0];
  assign bus.fs        = ctl_q[1];
  assign bus.h_db_o    = out_q;
  assign bus.h_db_oe_n = !(act_q && !rd_q);
  assign irq           = |(ist_q & msk_q);
endmodule : glcd_host
`default_nettype wire

// File: tb/glcd_properties.sv
// checker on the host/lcd parallel link
// assumes one clock domain; inputs tapped straight from the interface
`timescale 1ns/100ps
`default_nettype none
module glcd_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // link
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       cd,
  input wire logic [7:0] h_db_o,
  input wire logic       h_db_oe_n,
  input wire logic [7:0] d_db_o,
  input wire logic       d_db_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****
  // link rules
  // ****
  a_no_bus_fight: assert property (!(!h_db_oe_n && !d_db_oe_n))
    else $error("both ends drive the data bus");
  a_wr_in_frame: assert property (!wr_n |-> !cs_n && !h_db_oe_n)
    else $error("write strobe outside a driven frame");
  a_cd_steady: assert property (!cs_n && $past(!cs_n) |-> $stable(cd))
    else $error("command/data line moved inside a frame");
  a_wr_pulse_len: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
    else $error("write strobe length wrong");
  a_rd_pulse_len: assert property ($fell(rd_n) |-> !rd_n [*8] ##1 rd_n)
    else $error("read strobe length wrong");
  a_one_strobe: assert property (!(!wr_n && !rd_n))
    else $error("read and write strobes together");
  a_select_hold: assert property ($rose(wr_n) |-> !cs_n [*8])
    else $error("select dropped too early after write");
  a_dev_release: assert property ($rose(rd_n) |-> ##[1:5] d_db_oe_n)
    else $error("device kept the bus after read");
  a_status_shape: assert property (!d_db_oe_n && cd |-> (d_db_o & 8'hB3) == 8'h23)
    else $error("status byte has wrong fixed bits");
  c_data_write: cover property ($fell(wr_n) && !cd);
  c_data_read: cover property ($fell(rd_n) && !cd);
  c_status_read: cover property ($fell(rd_n) && cd);
endmodule : glcd_properties
`default_nettype wire

// File: tb/tb_glcd.sv
// self-checking bench: host controller and lcd decoder back to back
// assumes the host register port is the only stimulus path besides the clock enable and reset
`timescale 1ns/100ps
`default_nettype none
`include "glcd_defines.svh"
module tb_glcd;
  logic        clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, we = 1'b0, re = 1'b0, re_q = 1'b0;
  logic [3:0]  addr = 4'h0, cell_width;
  logic [7:0]  wdata = 8'h00, rdata, v, b0, b1, b2, text_cols, gfx_cols, offset_reg;
  logic [15:0] ptr, text_home, gfx_home, cursor_pos, th;
  logic [2:0]  merge_mode, cursor_lines, k;
  logic        cg_external, text_on, gfx_on, cursor_on, cursor_blink, auto_active;
  logic        peek_error_flag, irq;
  logic [7:0]  exp_q[$], msk_q[$];
  logic [2:0]  mt[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  int          num_errors = 0, cmp_count = 0;
  glcd_bus_if bif();
  glcd_host u_glcd_host (.clock(clock), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .irq(irq), .bus(bif));
  glcd_dev u_glcd_dev (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus(bif), .ptr(ptr),
    .text_home(text_home), .text_cols(text_cols), .gfx_home(gfx_home), .gfx_cols(gfx_cols),
    .cursor_pos(cursor_pos), .offset_reg(offset_reg), .merge_mode(merge_mode),
    .cg_external(cg_external), .text_on(text_on), .gfx_on(gfx_on), .cursor_on(cursor_on),
    .cursor_blink(cursor_blink), .cursor_lines(cursor_lines), .cell_width(cell_width),
    .auto_active(auto_active), .peek_error_flag(peek_error_flag));
  glcd_properties u_glcd_properties (.clock(clock), .sys_rst(sys_rst), .cs_n(bif.cs_n),
    .wr_n(bif.wr_n), .rd_n(bif.rd_n), .cd(bif.cd), .h_db_o(bif.h_db_o),
    .h_db_oe_n(bif.h_db_oe_n), .d_db_o(bif.d_db_o), .d_db_oe_n(bif.d_db_oe_n));
  initial begin
    forever #5 clock = ~clock;
  end
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // ****
  // register port and link transfers
  // ****
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask : wr
  // expectation noted here, compared by the monitor; mask 0 means poll only
  task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clock);
    re <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task send(input logic [1:0] m, input logic [7:0] b);
    int n;
    wr(4'h1, {6'h00, m});
    wr(4'h0, b);
    n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 200) begin
      rd(4'h4, 8'h00, 8'h00);
      n++;
    end
    if (v[0] !== 1'b0) begin
      num_errors++;
      results();
    end
  endtask : send
  task cmd2(input logic [15:0] d, input logic [7:0] c);
    send(2'b00, d[7:0]);
    send(2'b00, d[15:8]);
    send(2'b01, c);
  endtask : cmd2
  task rdb(input logic [1:0] m, input logic [7:0] e);
    send(m, 8'h00);
    rd(4'h5, e, 8'hFF);
  endtask : rdb
  always @(posedge clock) begin
    re_q <= re;
    if (re_q && exp_q.size() > 0) begin
      if (msk_q[0] !== 8'h00) check("rdata", 16'(rdata & msk_q[0]), 16'(exp_q[0] & msk_q[0]));
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    th = 16'($urandom(26));
    {b0, b1, b2} = 24'($urandom());
    k = 3'($urandom());
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    wr(4'h8, 8'h01);
    wr(4'hD, 8'h03);
    rd(4'h3, 8'h00, 8'hFF);
    rd(4'h8, 8'h01, 8'hFF);
    check("cell_width", 16'(cell_width), 16'(`GL_CELL_WIDE));
    // irq raised, masked, cleared by reading
    send(2'b01, 8'h90);
    check("irq", 16'(irq), 16'h0001);
    wr(4'hD, 8'h00);
    repeat (2) @(negedge clock);
    check("irq", 16'(irq), 16'h0000);
    wr(4'hD, 8'h03);
    rd(4'hC, 8'h01, 8'hFF);
    repeat (2) @(negedge clock);
    check("irq", 16'(irq), 16'h0000);
    for (int d = 0; d < 16; d++) begin
      send(2'b01, 8'h90 | 8'(d));
      check("disp", 16'({gfx_on, text_on, cursor_on, cursor_blink}), 16'(d));
    end
    for (int i = 0; i < 4; i++) begin
      send(2'b01, {4'h8, i[0], mt[i]});
      check("mode", 16'({cg_external, merge_mode}), 16'({i[0], mt[i]}));
    end
    cmd2(th, 8'h40);
    check("text_home", text_home, th);
    cmd2(16'h0400, 8'h42);
    check("gfx_home", gfx_home, 16'h0400);
    cmd2(16'h0001, 8'h43);
    check("gfx_cols", 16'(gfx_cols), 16'h0001);
    cmd2(16'h001E, 8'h41);
    check("text_cols", 16'(text_cols), 16'h001E);
    cmd2(16'h0305, 8'h21);
    check("cursor_pos", cursor_pos, 16'h0305);
    cmd2({8'h00, b2}, 8'h22);
    check("offset_reg", 16'(offset_reg), 16'(b2));
    send(2'b01, {5'h14, k});
    check("cursor_lines", 16'(cursor_lines), 16'(k));
    wr(4'h8, 8'h03);
    // pointer stepping of single transfers
    cmd2(16'h0100, 8'h24);
    send(2'b00, 8'hAA);
    send(2'b01, 8'hC0);
    check("ptr", ptr, 16'h0101);
    send(2'b00, 8'h55);
    send(2'b01, 8'hC2);
    check("ptr", ptr, 16'h0100);
    send(2'b00, 8'h5A);
    send(2'b01, 8'hC4);
    check("ptr", ptr, 16'h0100);
    check("cell_width", 16'(cell_width), 16'(`GL_CELL_NARROW));
    send(2'b01, 8'hC5);
    rdb(2'b10, 8'h5A);
    rd(4'hC, 8'h02, 8'h02);
    send(2'b01, 8'hC1);
    rdb(2'b10, 8'h5A);
    check("ptr", ptr, 16'h0101);
    send(2'b01, 8'hC3);
    rdb(2'b10, 8'h55);
    check("ptr", ptr, 16'h0100);
    // auto write refuses commands until auto reset
    cmd2(16'h0200, 8'h24);
    send(2'b01, 8'hB0);
    rdb(2'b11, 8'h2B);
    send(2'b00, b0);
    send(2'b00, b1);
    send(2'b00, b2);
    send(2'b01, 8'h40);
    check("text_home", text_home, th);
    check("auto", 16'(auto_active), 16'h0001);
    send(2'b01, 8'hB2);
    check("ptr", ptr, 16'h0203);
    rdb(2'b11, 8'h23);
    cmd2(16'h0200, 8'h24);
    send(2'b01, 8'hB1);
    rdb(2'b11, 8'h27);
    rdb(2'b10, b0);
    rdb(2'b10, b1);
    send(2'b01, 8'hB2);
    check("ptr", ptr, 16'h0202);
    cmd2(16'h0201, 8'h24);
    send(2'b01, 8'hC5);
    rdb(2'b10, b1);
    // peek outside then inside the graphic area
    cmd2(16'h0000, 8'h24);
    send(2'b01, 8'hE0);
    check("peek_err", 16'(peek_error_flag), 16'h0001);
    rdb(2'b11, 8'h63);
    cmd2(16'h0400, 8'h24);
    send(2'b00, b2);
    send(2'b01, 8'hC4);
    send(2'b01, 8'hE0);
    check("peek_err", 16'(peek_error_flag), 16'h0000);
    rdb(2'b10, b2);
    // single bit set then reset
    cmd2(16'h0300, 8'h24);
    send(2'b00, 8'h00);
    send(2'b01, 8'hC4);
    send(2'b01, {5'h1F, k});
    send(2'b01, 8'hC5);
    rdb(2'b10, 8'h01 << k);
    send(2'b00, 8'hFF);
    send(2'b01, 8'hC4);
    send(2'b01, {5'h1E, k});
    send(2'b01, 8'hC5);
    rdb(2'b10, ~(8'h01 << k));
    // a register write while the clock enable is low must not land
    @(posedge clock);
    ce <= 1'b0;
    wr(4'h8, 8'h00);
    ce <= 1'b1;
    rd(4'h8, 8'h03, 8'hFF);
    // reset pin abandons auto mode
    send(2'b01, 8'hB0);
    wr(4'h8, 8'h02);
    repeat (8) @(posedge clock);
    wr(4'h8, 8'h03);
    check("auto", 16'(auto_active), 16'h0000);
    check("text_home", text_home, 16'h0000);
    results();
  end
endmodule : tb_glcd
`default_nettype wire
